// ---- core/csb_alu.sv ----
// Combinational ALU: result and zero, digit-carry, carry flags with affect masks.
// Assumes operands are already selected by the register bank.
`timescale 1ns/1ps
module csb_alu (
	input wire csb_pkg::csb_op_t i_op,
	input wire logic [7:0] i_w,
	input wire logic [7:0] i_f,
	input wire logic i_c,
	input wire logic [2:0] i_bit,
	output logic [7:0] o_result,
	output logic o_z,
	output logic o_dc,
	output logic o_c,
	output logic o_aff_z,
	output logic o_aff_dc,
	output logic o_aff_c
);
	logic [8:0] add_full;
	logic [8:0] sub_full;
	logic [4:0] add_low;
	logic [4:0] sub_low;
	logic [7:0] bit_one;
	assign add_full = {1'b0, i_f} + {1'b0, i_w};
	assign sub_full = {1'b0, i_f} + {1'b0, ~i_w} + 9'h001;
	assign add_low = {1'b0, i_f[3:0]} + {1'b0, i_w[3:0]};
	assign sub_low = {1'b0, i_f[3:0]} + {1'b0, ~i_w[3:0]} + 5'h01;
	assign bit_one = 8'h01 << i_bit;
	assign o_z = (o_result == 8'h00);
	always_comb begin
		o_result = i_f;
		o_dc = 1'b0;
		o_c = 1'b0;
		o_aff_z = 1'b1;
		o_aff_dc = 1'b0;
		o_aff_c = 1'b0;
		case (i_op)
			csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR: begin
				o_result = i_w;
				o_aff_z = 1'b0;
			end
			csb_pkg::CSB_OP_CLR: o_result = 8'h00;
			csb_pkg::CSB_OP_ADD: begin
				o_result = add_full[7:0];
				o_dc = add_low[4];
				o_c = add_full[8];
				o_aff_dc = 1'b1;
				o_aff_c = 1'b1;
			end
			csb_pkg::CSB_OP_SUB: begin
				// Carry out of f + ~w + 1 is one exactly when no borrow occurs
				o_result = sub_full[7:0];
				o_dc = sub_low[4];
				o_c = sub_full[8];
				o_aff_dc = 1'b1;
				o_aff_c = 1'b1;
			end
			csb_pkg::CSB_OP_AND: o_result = i_f & i_w;
			csb_pkg::CSB_OP_IOR: o_result = i_f | i_w;
			csb_pkg::CSB_OP_XOR: o_result = i_f ^ i_w;
			csb_pkg::CSB_OP_MOVF: o_result = i_f;
			csb_pkg::CSB_OP_COM: o_result = ~i_f;
			csb_pkg::CSB_OP_INC: o_result = i_f + 8'h01;
			csb_pkg::CSB_OP_DEC: o_result = i_f - 8'h01;
			csb_pkg::CSB_OP_RRF: begin
				o_result = {i_c, i_f[7:1]};
				o_c = i_f[0];
				o_aff_z = 1'b0;
				o_aff_c = 1'b1;
			end
			csb_pkg::CSB_OP_RLF: begin
				o_result = {i_f[6:0], i_c};
				o_c = i_f[7];
				o_aff_z = 1'b0;
				o_aff_c = 1'b1;
			end
			csb_pkg::CSB_OP_SWAP: begin
				o_result = {i_f[3:0], i_f[7:4]};
				o_aff_z = 1'b0;
			end
			csb_pkg::CSB_OP_BCF: begin
				o_result = i_f & ~bit_one;
				o_aff_z = 1'b0;
			end
			csb_pkg::CSB_OP_BSF: begin
				o_result = i_f | bit_one;
				o_aff_z = 1'b0;
			end
			default: o_result = i_f;
		endcase
	end
endmodule

// ---- core/csb_core_regs.sv ----
// Core special-function register bank with general purpose file and flag logic.
// Assumes a core decoder presents one instruction step per i_exec pulse on i_clk,
// and that reset cause and wake cause inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "csb_regs.svh"
module csb_core_regs #(
	parameter bit HAS_COMPARATOR = 1'b1,
	parameter int GPR_DEPTH = 24
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ext_reset,
	input wire logic i_wake_pin,
	input wire logic i_wake_cmp,
	input wire logic i_exec,
	input wire csb_pkg::csb_op_t i_op,
	input wire logic [4:0] i_file_addr,
	input wire logic [7:0] i_w,
	input wire logic [2:0] i_bit,
	input wire logic i_dest_f,
	input wire logic i_option_load,
	input wire logic i_dir_load,
	input wire logic i_watchdog_clear,
	input wire logic i_sleep,
	input wire logic i_watchdog_timeout,
	input wire logic i_pc_step,
	input wire logic i_pc_load,
	input wire logic [7:0] i_pc_value,
	input wire logic i_timer_tick,
	input wire logic [3:0] i_pins,
	input wire logic i_cmp_level,
	output logic [7:0] o_result,
	output logic o_result_valid,
	output logic [7:0] o_status,
	output logic [7:0] o_program_counter_low,
	output logic [7:0] o_timer_count_value,
	output logic [7:0] o_indirect_address_pointer,
	output logic [7:0] o_oscillator_trim,
	output logic [3:0] o_pin_latch,
	output logic [7:0] o_comparator_setup,
	output logic [7:0] o_timer_watchdog_options,
	output logic [3:0] o_pin_direction
);
	logic [7:0] gpr [GPR_DEPTH];
	logic [7:0] timer_count_value;
	logic [7:0] program_counter_low;
	logic [7:0] indirect_address_pointer;
	logic [7:0] oscillator_trim;
	logic [3:0] pin_latch;
	logic [7:0] comparator_setup;
	logic [7:0] timer_watchdog_options;
	logic [3:0] pin_direction;
	logic pin_wake_flag, comparator_wake_flag, timeout_flag, powerdown_flag;
	logic zero_flag, digit_carry_flag, carry_flag;
	logic [3:0] pins_meta, pins_sync;
	logic cmp_meta, cmp_sync;
	logic any_reset;
	logic [4:0] eff_addr;
	logic [7:0] status_view, cmp_view, file_rd;
	logic [7:0] alu_res;
	logic alu_z, alu_dc, alu_c, aff_z, aff_dc, aff_c;
	logic file_wr;
	logic wr_timer, wr_pcl, wr_status, wr_pointer, wr_trim, wr_pins, wr_cmp, wr_gpr;
	logic [4:0] gpr_index;
	logic next_z, next_dc, next_c, step_ok, flag_op;

	// Any reset source presets the option, direction, PROGRAM_COUNTER_LOW and pointer registers
	assign any_reset = !i_resetn || i_ext_reset;
	// Indirect access through address zero; pointing back at zero reads zero and writes nothing
	assign eff_addr = (i_file_addr == `CSB_ADDR_INDIRECT) ? indirect_address_pointer[4:0] : i_file_addr;
	assign gpr_index = eff_addr - `CSB_ADDR_GPR_BASE;
	assign status_view = {pin_wake_flag, comparator_wake_flag, 1'b1, timeout_flag, powerdown_flag,
		zero_flag, digit_carry_flag, carry_flag};
	assign cmp_view = HAS_COMPARATOR ? {cmp_sync, comparator_setup[6:0]} : `CSB_ABSENT_CMP;
	always_comb begin
		file_rd = 8'h00;
		case (eff_addr)
			`CSB_ADDR_INDIRECT: file_rd = 8'h00;
			`CSB_ADDR_TIMER: file_rd = timer_count_value;
			`CSB_ADDR_PCL: file_rd = program_counter_low;
			`CSB_ADDR_STATUS: file_rd = status_view;
			`CSB_ADDR_POINTER: file_rd = indirect_address_pointer;
			`CSB_ADDR_TRIM: file_rd = oscillator_trim;
			`CSB_ADDR_PINS: file_rd = {4'h0, pins_sync};
			`CSB_ADDR_CMP: file_rd = cmp_view;
			default: file_rd = (int'(gpr_index) < GPR_DEPTH) ? gpr[gpr_index] : 8'h00;
		endcase
	end

	csb_alu u_alu (
		.i_op(i_op),
		.i_w(i_w),
		.i_f(file_rd),
		.i_c(carry_flag),
		.i_bit(i_bit),
		.o_result(alu_res),
		.o_z(alu_z),
		.o_dc(alu_dc),
		.o_c(alu_c),
		.o_aff_z(aff_z),
		.o_aff_dc(aff_dc),
		.o_aff_c(aff_c)
	);

	assign file_wr = i_exec && i_dest_f && !any_reset;
	assign wr_timer = file_wr && (eff_addr == `CSB_ADDR_TIMER);
	assign wr_pcl = file_wr && (eff_addr == `CSB_ADDR_PCL);
	assign wr_status = file_wr && (eff_addr == `CSB_ADDR_STATUS);
	assign wr_pointer = file_wr && (eff_addr == `CSB_ADDR_POINTER);
	assign wr_trim = file_wr && (eff_addr == `CSB_ADDR_TRIM);
	assign wr_pins = file_wr && (eff_addr == `CSB_ADDR_PINS);
	assign wr_cmp = file_wr && (eff_addr == `CSB_ADDR_CMP) && HAS_COMPARATOR;
	assign wr_gpr = file_wr && (eff_addr >= `CSB_ADDR_GPR_BASE) && (int'(gpr_index) < GPR_DEPTH);

	// A step that lands in a non-power reset is dropped, flag updates included
	assign step_ok = i_exec && !i_ext_reset;
	assign flag_op = aff_z || aff_dc || aff_c;
	// Any flag-affecting op masks the data write to all three arithmetic bits
	always_comb begin
		next_z = zero_flag;
		next_dc = digit_carry_flag;
		next_c = carry_flag;
		if (step_ok && aff_z) begin
			next_z = alu_z;
		end else if (wr_status && !flag_op) begin
			next_z = alu_res[`CSB_BIT_Z];
		end
		if (step_ok && aff_dc) begin
			next_dc = alu_dc;
		end else if (wr_status && !flag_op) begin
			next_dc = alu_res[`CSB_BIT_DC];
		end
		if (step_ok && aff_c) begin
			next_c = alu_c;
		end else if (wr_status && !flag_op) begin
			next_c = alu_res[`CSB_BIT_C];
		end
	end

	always_ff @(posedge i_clk) begin
		pins_meta <= i_pins;
		pins_sync <= pins_meta;
		cmp_meta <= i_cmp_level;
		cmp_sync <= cmp_meta;
	end

	// Arithmetic flags are undefined at power-up; cleared here for a defined start
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			zero_flag <= 1'b0;
			digit_carry_flag <= 1'b0;
			carry_flag <= 1'b0;
		end else begin
			zero_flag <= next_z;
			digit_carry_flag <= next_dc;
			carry_flag <= next_c;
		end
	end

	// Wake causes come only with a reset, so a reset event always wins over a data write
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pin_wake_flag <= 1'b0;
			comparator_wake_flag <= 1'b0;
		end else if (i_ext_reset) begin
			pin_wake_flag <= i_wake_pin;
			comparator_wake_flag <= HAS_COMPARATOR && i_wake_cmp;
		end else if (wr_status) begin
			pin_wake_flag <= alu_res[`CSB_BIT_PIN_WAKE_FLAG];
			comparator_wake_flag <= HAS_COMPARATOR && alu_res[`CSB_BIT_COMPARATOR_WAKE_FLAG];
		end
	end

	// Time-out and power-down see no data path at all
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b1;
		end else if (i_watchdog_timeout) begin
			timeout_flag <= 1'b0;
		end else if (i_watchdog_clear) begin
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b1;
		end else if (i_sleep) begin
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			program_counter_low <= `CSB_RST_PCL;
			indirect_address_pointer <= `CSB_RST_POINTER;
			comparator_setup <= `CSB_RST_CMP;
			timer_watchdog_options <= `CSB_RST_OPTION;
			pin_direction <= `CSB_RST_DIR;
		end else begin
			if (wr_pcl) begin
				program_counter_low <= alu_res;
			end else if (i_pc_load) begin
				program_counter_low <= i_pc_value;
			end else if (i_pc_step) begin
				program_counter_low <= program_counter_low + 8'h01;
			end
			if (wr_pointer) begin
				indirect_address_pointer <= alu_res;
			end
			if (wr_cmp) begin
				comparator_setup <= alu_res;
			end
			if (i_option_load) begin
				timer_watchdog_options <= i_w;
			end
			if (i_dir_load) begin
				pin_direction <= i_w[3:0];
			end
		end
	end

	// Trim keeps its value over non-power resets so calibration survives a watchdog reset
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			oscillator_trim <= `CSB_RST_TRIM;
			timer_count_value <= 8'h00;
			pin_latch <= 4'h0;
		end else begin
			if (wr_trim) begin
				oscillator_trim <= alu_res;
			end
			if (wr_timer) begin
				timer_count_value <= alu_res;
			end else if (i_timer_tick) begin
				timer_count_value <= timer_count_value + 8'h01;
			end
			if (wr_pins) begin
				pin_latch <= alu_res[3:0];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (wr_gpr) begin
			gpr[gpr_index] <= alu_res;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_result <= 8'h00;
			o_result_valid <= 1'b0;
		end else begin
			o_result <= alu_res;
			o_result_valid <= i_exec && !i_ext_reset;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_status <= 8'h00;
			o_program_counter_low <= `CSB_RST_PCL;
			o_timer_count_value <= 8'h00;
			o_indirect_address_pointer <= `CSB_RST_POINTER;
			o_oscillator_trim <= `CSB_RST_TRIM;
			o_pin_latch <= 4'h0;
			o_comparator_setup <= `CSB_RST_CMP;
			o_timer_watchdog_options <= `CSB_RST_OPTION;
			o_pin_direction <= `CSB_RST_DIR;
		end else begin
			o_status <= status_view;
			o_program_counter_low <= program_counter_low;
			o_timer_count_value <= timer_count_value;
			o_indirect_address_pointer <= indirect_address_pointer;
			o_oscillator_trim <= oscillator_trim;
			o_pin_latch <= pin_latch;
			o_comparator_setup <= cmp_view;
			o_timer_watchdog_options <= timer_watchdog_options;
			o_pin_direction <= pin_direction;
		end
	end
endmodule

// ---- core/csb_pkg.sv ----
// Types shared by the register bank and its ALU.
// Assumes the instruction decoder outside names its operation with this enum.
package csb_pkg;
	typedef enum logic [3:0] {
		CSB_OP_MOVE_WORKING_TO_FILE_INSTR, CSB_OP_CLR, CSB_OP_ADD, CSB_OP_SUB, CSB_OP_AND, CSB_OP_IOR, CSB_OP_XOR, CSB_OP_MOVF,
		CSB_OP_COM, CSB_OP_INC, CSB_OP_DEC, CSB_OP_RRF, CSB_OP_RLF, CSB_OP_SWAP, CSB_OP_BCF, CSB_OP_BSF
	} csb_op_t;
endpackage

// ---- core/csb_regs.svh ----
// Register bank constants: file addresses, status bit positions, reset values.
// Assumes a 5-bit file address space and an 8-bit data path.
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH
`define CSB_ADDR_INDIRECT 5'h00
`define CSB_ADDR_TIMER 5'h01
`define CSB_ADDR_PCL 5'h02
`define CSB_ADDR_STATUS 5'h03
`define CSB_ADDR_POINTER 5'h04
`define CSB_ADDR_TRIM 5'h05
`define CSB_ADDR_PINS 5'h06
`define CSB_ADDR_CMP 5'h07
`define CSB_ADDR_GPR_BASE 5'h08
`define CSB_BIT_C 0
`define CSB_BIT_DC 1
`define CSB_BIT_Z 2
`define CSB_BIT_PD 3
`define CSB_BIT_TO 4
`define CSB_BIT_RSVD 5
`define CSB_BIT_COMPARATOR_WAKE_FLAG 6
`define CSB_BIT_PIN_WAKE_FLAG 7
`define CSB_RST_PCL 8'hFF
`define CSB_RST_POINTER 8'hE0
`define CSB_RST_TRIM 8'hFE
`define CSB_RST_CMP 8'hFF
`define CSB_RST_OPTION 8'hFF
`define CSB_RST_DIR 4'hF
`define CSB_ABSENT_CMP 8'h00
`endif

// ---- tb/csb_core_regs_monitor.sv ----
// Checker for the core register bank: flag events, reset defaults, result timing.
// Assumes it is bound to csb_core_regs and sees only its ports.
`timescale 1ns/1ps
module csb_core_regs_monitor #(
	parameter bit HAS_COMPARATOR = 1'b1,
	parameter int GPR_DEPTH = 24
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ext_reset,
	input wire logic i_wake_pin,
	input wire logic i_exec,
	input wire csb_pkg::csb_op_t i_op,
	input wire logic i_sleep,
	input wire logic i_watchdog_clear,
	input wire logic i_watchdog_timeout,
	input wire logic [7:0] o_result,
	input wire logic o_result_valid,
	input wire logic [7:0] o_status,
	input wire logic [7:0] o_program_counter_low,
	input wire logic [7:0] o_indirect_address_pointer,
	input wire logic [7:0] o_timer_watchdog_options,
	input wire logic [3:0] o_pin_direction
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Status mirror is forced low in reset, so wait three clean edges
	property p_bit5_one;
		$past(i_resetn) && $past(i_resetn, 2) && $past(i_resetn, 3) |-> o_status[5];
	endproperty
	a_bit5_one: assert property (p_bit5_one) else $error("status bit 5 low");
	property p_valid_follows;
		i_exec && !i_ext_reset |=> o_result_valid;
	endproperty
	a_valid_follows: assert property (p_valid_follows) else $error("result valid missing");
	property p_valid_only;
		!i_exec |=> !o_result_valid;
	endproperty
	a_valid_only: assert property (p_valid_only) else $error("result valid without step");
	property p_sleep;
		i_sleep && !i_watchdog_timeout && !i_watchdog_clear |=> ##1 (o_status[4:3] == 2'b10);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
	property p_timeout;
		i_watchdog_timeout |=> ##1 !o_status[4];
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out flag not cleared");
	property p_wdt_clear;
		i_watchdog_clear && !i_watchdog_timeout |=> ##1 (o_status[4:3] == 2'b11);
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear flags wrong");
	property p_to_pd_stable;
		$past(i_resetn) && $past(i_resetn, 2) && !i_sleep && !i_watchdog_timeout && !i_watchdog_clear
			|=> ##1 $stable(o_status[4:3]);
	endproperty
	a_to_pd_stable: assert property (p_to_pd_stable) else $error("flags moved without event");
	property p_wake;
		i_ext_reset |=> ##1 (o_status[7] == $past(i_wake_pin, 2));
	endproperty
	a_wake: assert property (p_wake) else $error("pin wake flag wrong");
	property p_ext_defaults;
		i_ext_reset |=> ##1 (o_program_counter_low == 8'hFF && o_indirect_address_pointer == 8'hE0
			&& o_timer_watchdog_options == 8'hFF && o_pin_direction == 4'hF);
	endproperty
	a_ext_defaults: assert property (p_ext_defaults) else $error("reset defaults wrong");
	property p_zero_flag;
		o_result_valid && $past(i_op) == csb_pkg::CSB_OP_ADD |=> (o_status[2] == ($past(o_result) == 8'h00));
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
endmodule
bind csb_core_regs csb_core_regs_monitor #(.HAS_COMPARATOR(HAS_COMPARATOR), .GPR_DEPTH(GPR_DEPTH)) u_monitor (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_ext_reset(i_ext_reset), .i_wake_pin(i_wake_pin), .i_exec(i_exec),
	.i_op(i_op), .i_sleep(i_sleep), .i_watchdog_clear(i_watchdog_clear), .i_watchdog_timeout(i_watchdog_timeout),
	.o_result(o_result), .o_result_valid(o_result_valid), .o_status(o_status),
	.o_program_counter_low(o_program_counter_low), .o_indirect_address_pointer(o_indirect_address_pointer),
	.o_timer_watchdog_options(o_timer_watchdog_options), .o_pin_direction(o_pin_direction));

// ---- tb/csb_core_regs_tb.sv ----
// Testbench: instruction steps and event pulses against the core register bank.
// Assumes one 25 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module csb_core_regs_tb;
	logic i_clk, i_resetn, i_ext_reset, i_wake_pin, i_wake_cmp, i_exec, i_dest_f, i_option_load, i_dir_load;
	logic i_watchdog_clear, i_sleep, i_watchdog_timeout, i_pc_step, i_pc_load, i_timer_tick, i_cmp_level;
	csb_pkg::csb_op_t i_op;
	logic [4:0] i_file_addr;
	logic [7:0] i_w, i_pc_value, o_result, o_status, o_program_counter_low, o_timer_count_value;
	logic [7:0] o_indirect_address_pointer, o_oscillator_trim, o_comparator_setup, o_timer_watchdog_options;
	logic [3:0] o_pin_latch, o_pin_direction, i_pins;
	logic [2:0] i_bit;
	logic o_result_valid;
	int n_mismatch, samples_checked, cycles;
	csb_core_regs uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ext_reset(i_ext_reset), .i_wake_pin(i_wake_pin),
		.i_wake_cmp(i_wake_cmp), .i_exec(i_exec), .i_op(i_op), .i_file_addr(i_file_addr), .i_w(i_w),
		.i_bit(i_bit), .i_dest_f(i_dest_f), .i_option_load(i_option_load), .i_dir_load(i_dir_load),
		.i_watchdog_clear(i_watchdog_clear), .i_sleep(i_sleep), .i_watchdog_timeout(i_watchdog_timeout),
		.i_pc_step(i_pc_step), .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_timer_tick(i_timer_tick),
		.i_pins(i_pins), .i_cmp_level(i_cmp_level), .o_result(o_result), .o_result_valid(o_result_valid),
		.o_status(o_status), .o_program_counter_low(o_program_counter_low),
		.o_timer_count_value(o_timer_count_value), .o_indirect_address_pointer(o_indirect_address_pointer),
		.o_oscillator_trim(o_oscillator_trim), .o_pin_latch(o_pin_latch), .o_comparator_setup(o_comparator_setup),
		.o_timer_watchdog_options(o_timer_watchdog_options), .o_pin_direction(o_pin_direction));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard; the whole sequence needs about a hundred cycles
	always @(posedge i_clk) begin
		cycles++;
		if (cycles > 500) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// One instruction step; status mirror is read two edges after launch
	task ex(input csb_pkg::csb_op_t op, input logic [4:0] a, input logic [7:0] w, input logic d,
		input logic [7:0] res, input logic [7:0] st);
		i_op = op;
		i_file_addr = a;
		i_w = w;
		i_dest_f = d;
		i_exec = 1'b1;
		@(posedge i_clk);
		#1 i_exec = 1'b0;
		`CHK("valid", 1'b1, o_result_valid)
		`CHK("result", res, o_result)
		@(posedge i_clk);
		#1 `CHK("status", st, o_status)
	endtask
	// Event pulse: {tick, step, wake, dir, option, ext, clear, timeout, sleep}
	task ev(input logic [8:0] e, input logic [7:0] w, input logic [7:0] st);
		{i_timer_tick, i_pc_step, i_wake_pin, i_dir_load, i_option_load, i_ext_reset, i_watchdog_clear,
			i_watchdog_timeout, i_sleep} = e;
		i_w = w;
		@(posedge i_clk);
		#1 {i_timer_tick, i_pc_step, i_wake_pin, i_dir_load, i_option_load, i_ext_reset, i_watchdog_clear,
			i_watchdog_timeout, i_sleep} = 9'h000;
		@(posedge i_clk);
		#1 `CHK("status", st, o_status)
	endtask
	initial begin
		{i_resetn, i_ext_reset, i_wake_pin, i_wake_cmp, i_exec, i_dest_f, i_option_load, i_dir_load} = 8'h00;
		{i_watchdog_clear, i_sleep, i_watchdog_timeout, i_pc_step, i_pc_load, i_timer_tick} = 6'h00;
		i_cmp_level = 1'b1;
		i_op = csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR;
		{i_file_addr, i_w, i_pc_value, i_pins, i_bit} = 28'h0000000;
		repeat (4) @(posedge i_clk);
		#1 i_resetn = 1'b1;
		repeat (2) @(posedge i_clk);
		#1 `CHK("status", 8'h38, o_status)
		`CHK("pcl", 8'hFF, o_program_counter_low)
		`CHK("option", 8'hFF, o_timer_watchdog_options)
		`CHK("direction", 4'hF, o_pin_direction)
		`CHK("trim", 8'hFE, o_oscillator_trim)
		`CHK("comparator", 8'hFF, o_comparator_setup)
		`CHK("latch", 4'h0, o_pin_latch)
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h08, 8'hFF, 1'b1, 8'hFF, 8'h38);
		ex(csb_pkg::CSB_OP_ADD, 5'h08, 8'h01, 1'b1, 8'h00, 8'h3F);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h03, 8'h03, 1'b1, 8'h03, 8'h3B);
		ex(csb_pkg::CSB_OP_CLR, 5'h03, 8'h00, 1'b1, 8'h00, 8'h3F);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h03, 8'h00, 1'b1, 8'h00, 8'h38);
		ex(csb_pkg::CSB_OP_ADD, 5'h03, 8'hC8, 1'b1, 8'h00, 8'h3F);
		ex(csb_pkg::CSB_OP_SUB, 5'h08, 8'h01, 1'b0, 8'hFF, 8'h38);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h08, 8'h81, 1'b1, 8'h81, 8'h38);
		ex(csb_pkg::CSB_OP_RRF, 5'h08, 8'h00, 1'b1, 8'h40, 8'h39);
		ex(csb_pkg::CSB_OP_RLF, 5'h08, 8'h00, 1'b1, 8'h81, 8'h38);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h04, 8'h08, 1'b1, 8'h08, 8'h38);
		ex(csb_pkg::CSB_OP_MOVF, 5'h00, 8'h00, 1'b0, 8'h81, 8'h38);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h00, 8'h5A, 1'b1, 8'h5A, 8'h38);
		ex(csb_pkg::CSB_OP_BSF, 5'h08, 8'h00, 1'b1, 8'h5B, 8'h38);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h02, 8'h10, 1'b1, 8'h10, 8'h38);
		ev(9'h080, 8'h00, 8'h38);
		`CHK("pcl", 8'h11, o_program_counter_low)
		ev(9'h100, 8'h00, 8'h38);
		`CHK("timer", 8'h01, o_timer_count_value)
		ev(9'h001, 8'h00, 8'h30);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h03, 8'h08, 1'b1, 8'h08, 8'h30);
		ev(9'h002, 8'h00, 8'h20);
		ev(9'h004, 8'h00, 8'h38);
		ev(9'h010, 8'h5A, 8'h38);
		`CHK("option", 8'h5A, o_timer_watchdog_options)
		ev(9'h020, 8'h03, 8'h38);
		`CHK("direction", 4'h3, o_pin_direction)
		ev(9'h048, 8'h00, 8'hB8);
		`CHK("pointer", 8'hE0, o_indirect_address_pointer)
		`CHK("option", 8'hFF, o_timer_watchdog_options)
		`CHK("direction", 4'hF, o_pin_direction)
		`CHK("pcl", 8'hFF, o_program_counter_low)
		ev(9'h008, 8'h00, 8'h38);
		i_pins = 4'h5;
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h06, 8'h0A, 1'b1, 8'h0A, 8'h38);
		`CHK("latch", 4'hA, o_pin_latch)
		ex(csb_pkg::CSB_OP_MOVF, 5'h06, 8'h00, 1'b0, 8'h05, 8'h38);
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h05, 8'h80, 1'b1, 8'h80, 8'h38);
		`CHK("trim", 8'h80, o_oscillator_trim)
		ex(csb_pkg::CSB_OP_MOVE_WORKING_TO_FILE_INSTR, 5'h07, 8'h12, 1'b1, 8'h12, 8'h38);
		`CHK("comparator", 8'h92, o_comparator_setup)
		i_wake_cmp = 1'b1;
		ev(9'h008, 8'h00, 8'h78);
		`CHK("comparator", 8'hFF, o_comparator_setup)
		i_wake_cmp = 1'b0;
		ex(csb_pkg::CSB_OP_CLR, 5'h03, 8'h00, 1'b1, 8'h00, 8'h3C);
		ex(csb_pkg::CSB_OP_COM, 5'h08, 8'h00, 1'b0, 8'hA4, 8'h38);
		ex(csb_pkg::CSB_OP_AND, 5'h08, 8'hA4, 1'b0, 8'h00, 8'h3C);
		ex(csb_pkg::CSB_OP_INC, 5'h08, 8'h00, 1'b0, 8'h5C, 8'h38);
		i_bit = 3'h3;
		ex(csb_pkg::CSB_OP_BCF, 5'h08, 8'h00, 1'b1, 8'h53, 8'h38);
		ex(csb_pkg::CSB_OP_SWAP, 5'h08, 8'h00, 1'b0, 8'h35, 8'h38);
		ex(csb_pkg::CSB_OP_XOR, 5'h08, 8'h53, 1'b0, 8'h00, 8'h3C);
		ex(csb_pkg::CSB_OP_IOR, 5'h08, 8'h00, 1'b0, 8'h53, 8'h38);
		ex(csb_pkg::CSB_OP_DEC, 5'h08, 8'h00, 1'b0, 8'h52, 8'h38);
		ex(csb_pkg::CSB_OP_RRF, 5'h03, 8'h00, 1'b1, 8'h1C, 8'h38);
		i_pc_value = 8'h33;
		i_pc_load = 1'b1;
		@(posedge i_clk);
		#1 i_pc_load = 1'b0;
		@(posedge i_clk);
		#1 `CHK("pcl", 8'h33, o_program_counter_low)
		give_verdict();
	end
endmodule
